// ---- shared/rijmp_regs.vh ----
// Constants for the register indirect jump unit: offsets, fields, encodings.
`ifndef RIJMP_REGS_VH
`define RIJMP_REGS_VH

// Register byte offsets on the AXI4-Lite bus.
`define RIJMP_OFF_CTRL 4'h0
`define RIJMP_OFF_STATUS 4'h4
`define RIJMP_OFF_TARGET 4'h8
`define RIJMP_OFF_COUNT 4'hc

// Control register fields.
`define RIJMP_CTRL_FULLPC_BIT 0
`define RIJMP_CTRL_SHORTISA_BIT 1
`define RIJMP_CTRL_NEWREL_BIT 2
`define RIJMP_CTRL_RESET 3'h4

// Status register fields.
`define RIJMP_ST_MODE_BIT 0
`define RIJMP_ST_SLOT_BIT 1
`define RIJMP_ST_ADDRERR_BIT 2
`define RIJMP_ST_RESINST_BIT 3

// Instruction word fields.
`define RIJMP_OP_HI 31
`define RIJMP_OP_LO 26
`define RIJMP_RS_HI 25
`define RIJMP_RS_LO 21
`define RIJMP_RT_HI 20
`define RIJMP_RT_LO 16
`define RIJMP_RD_HI 15
`define RIJMP_RD_LO 11
`define RIJMP_HINT_HI 10
`define RIJMP_HINT_LO 6
`define RIJMP_BARRIER_BIT 10
`define RIJMP_FN_HI 5
`define RIJMP_FN_LO 0

// Opcode and function encodings.
`define RIJMP_OPC_SHARED 6'h00
`define RIJMP_OPC_STORE_SLOT 6'h3e
`define RIJMP_OPC_LOAD_SLOT 6'h36
`define RIJMP_FN_REGJUMP_OLD 6'h08
`define RIJMP_FN_REGJUMP_LINK 6'h09

// Link register number and next sequential step.
`define RIJMP_LINK_REG 5'h1f
`define RIJMP_SEQ_STEP 32'h00000004

// AXI response codes.
`define RIJMP_RESP_OKAY 2'h0
`define RIJMP_RESP_SLVERR 2'h2

`endif

// ---- src/rijmp_unit.v ----
// Register indirect jump unit with its AXI4-Lite control registers.
// Operation
// - Linking indexed jump target is base register plus sign-extended offset.
// - Indexed jump offsets are added unshifted, bit for bit.
// - Linking indexed jump writes PC plus 4 into register 31.
// - Without short instruction set, unaligned target raises address error; with full-PC flag clear the code checks only bit 1.
// - With short set, mode bit takes target bit 0, target bit 0 cleared.
// - With short set, mode 0 and unaligned target raises address error; the code checks only bit 1, even with full-PC flag set.
// - Indexed jumps always taken, no delay slot, next instruction not run.
// - Full-PC flag set loads whole address, else split mode and target.
// - Linking indexed jump accepts base 31; base read before link write.
// - Linking indexed jump vs not-zero branch decided by bits 21-25 only.
// - Plain indexed jump vs equal-zero branch decided by register field.
// - Plain indexed jump forms target the same way, writes no link.
// - Register jump loads PC from source register after one delay slot.
// - With short set, register jump takes mode from source bit 0.
// - With short set, target bit 0 zero and bit 1 one is address error.
// - Newest release: transfer instruction in delay slot is reserved.
// - Old hint value 0 is default; bit 10 selects hazard barrier.
// - Newest release decodes register jump as link jump with rd zero.
// - Barrier form clears hazards before the target is fetched.
// - Barrier form is identified by instruction bit 10.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "rijmp_regs.vh"

module rijmp_unit (
    input wire core_clk,
    input wire rstn,
    input wire instValid,
    input wire [31:0] instWord,
    input wire [31:0] instPc,
    input wire [31:0] baseValue,
    input wire [31:0] srcValue,
    input wire slotInstIsCti,
    output wire [4:0] baseRegAddr,
    output wire [4:0] srcRegAddr,
    output reg linkWe,
    output reg [4:0] linkAddr,
    output reg [31:0] linkData,
    output reg redirectValid,
    output reg [31:0] redirectPc,
    output reg instruction_set_mode_bit,
    output reg addrError,
    output reg hazardClear,
    output reg reservedInst,
    output reg slotPending,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    reg [2:0] ctrl_q;
    reg [31:0] lastTarget_q;
    reg [31:0] jumpCount_q;
    reg lastAddrErr_q;
    reg lastResInst_q;

    wire fullPcFlag = ctrl_q[`RIJMP_CTRL_FULLPC_BIT];
    wire shortIsa = ctrl_q[`RIJMP_CTRL_SHORTISA_BIT];
    wire newRelease = ctrl_q[`RIJMP_CTRL_NEWREL_BIT];

    // Instruction fields.
    wire [5:0] opField = instWord[`RIJMP_OP_HI:`RIJMP_OP_LO];
    wire [4:0] rsField = instWord[`RIJMP_RS_HI:`RIJMP_RS_LO];
    wire [4:0] rtField = instWord[`RIJMP_RT_HI:`RIJMP_RT_LO];
    wire [4:0] rdField = instWord[`RIJMP_RD_HI:`RIJMP_RD_LO];
    wire [4:0] hintField = instWord[`RIJMP_HINT_HI:`RIJMP_HINT_LO];
    wire [5:0] fnField = instWord[`RIJMP_FN_HI:`RIJMP_FN_LO];

    assign baseRegAddr = rtField;
    assign srcRegAddr = rsField;

    // A nonzero register field means the slot belongs to the compact branch.
    wire isLinkIndexed = (opField == `RIJMP_OPC_STORE_SLOT) &&
        (rsField == 5'h00);
    wire isPlainIndexed = (opField == `RIJMP_OPC_LOAD_SLOT) &&
        (rsField == 5'h00);
    wire isShared = (opField == `RIJMP_OPC_SHARED);
    wire isRegJumpNew = isShared && newRelease &&
        (fnField == `RIJMP_FN_REGJUMP_LINK) && (rdField == 5'h00);
    // The old encoding is gone in the newest release.
    wire isRegJumpOld = isShared && !newRelease &&
        (fnField == `RIJMP_FN_REGJUMP_OLD) &&
        ((hintField == 5'h00) ||
        (hintField == 5'h10));
    wire isRegJump = isRegJumpNew || isRegJumpOld;
    wire isIndexed = isLinkIndexed || isPlainIndexed;
    wire barrierSel = instWord[`RIJMP_BARRIER_BIT];
    wire ownCti = isIndexed || isRegJump;

    // Indexed target: the offset is aligned with bit 0 of the base.
    wire [31:0] offsetExt = {{16{instWord[15]}}, instWord[15:0]};
    wire [31:0] indexedSum = baseValue + offsetExt;
    wire [31:0] rawTarget = isIndexed ? indexedSum : srcValue;

    reg [31:0] newPc;
    reg newMode;
    reg newErr;

    always @* begin
        newPc = rawTarget;
        newMode = instruction_set_mode_bit;
        newErr = 1'b0;
        if (!fullPcFlag) begin
            newPc = {rawTarget[31:1], 1'b0};
            newMode = rawTarget[0];
        end
        if (!shortIsa) begin
            newErr = (newPc[1:0] != 2'h0);
        end else begin
            // Mode 1 targets need only halfword alignment.
            newErr = !newMode && newPc[1];
        end
    end

    // Pending register jump, held across its delay slot.
    reg [31:0] pendPc_q;
    reg pendMode_q;
    reg pendErr_q;
    reg pendBarrier_q;

    wire slotCti = slotInstIsCti || ownCti;

    always @(posedge core_clk) begin
        if (!rstn) begin
            linkWe <= 1'b0;
            linkAddr <= 5'h00;
            linkData <= 32'h00000000;
            redirectValid <= 1'b0;
            redirectPc <= 32'h00000000;
            instruction_set_mode_bit <= 1'b0;
            addrError <= 1'b0;
            hazardClear <= 1'b0;
            reservedInst <= 1'b0;
            slotPending <= 1'b0;
            pendPc_q <= 32'h00000000;
            pendMode_q <= 1'b0;
            pendErr_q <= 1'b0;
            pendBarrier_q <= 1'b0;
        end else begin
            linkWe <= 1'b0;
            redirectValid <= 1'b0;
            addrError <= 1'b0;
            hazardClear <= 1'b0;
            reservedInst <= 1'b0;
            if (instValid && slotPending) begin
                slotPending <= 1'b0;
                if (slotCti && newRelease) begin
                    // The pending jump is abandoned to the exception.
                    reservedInst <= 1'b1;
                end else begin
                    // Older releases leave this case open; the slot word
                    // is ignored as a jump and the pending jump completes.
                    redirectValid <= 1'b1;
                    redirectPc <= pendPc_q;
                    instruction_set_mode_bit <= pendMode_q;
                    addrError <= pendErr_q;
                    hazardClear <= pendBarrier_q;
                end
            end else if (instValid && isIndexed) begin
                // Redirect kills the sequential word already fetched.
                redirectValid <= 1'b1;
                redirectPc <= newPc;
                instruction_set_mode_bit <= newMode;
                addrError <= newErr;
                // The sum used baseValue read this cycle, so base 31 is safe.
                linkWe <= isLinkIndexed;
                linkAddr <= `RIJMP_LINK_REG;
                linkData <= instPc + `RIJMP_SEQ_STEP;
            end else if (instValid && isRegJump) begin
                slotPending <= 1'b1;
                pendPc_q <= newPc;
                pendMode_q <= newMode;
                pendErr_q <= newErr;
                pendBarrier_q <= barrierSel;
            end
        end
    end

    // Observed state for software.
    always @(posedge core_clk) begin
        if (!rstn) begin
            lastTarget_q <= 32'h00000000;
            jumpCount_q <= 32'h00000000;
            lastAddrErr_q <= 1'b0;
            lastResInst_q <= 1'b0;
        end else begin
            if (redirectValid) begin
                lastTarget_q <= redirectPc;
                jumpCount_q <= jumpCount_q + 32'h00000001;
                lastAddrErr_q <= addrError;
            end
            if (redirectValid || reservedInst) begin
                lastResInst_q <= reservedInst;
            end
        end
    end

    // AXI4-Lite slave: address and data may arrive in either order.
    reg awHeld_q;
    reg [3:0] awAddr_q;
    reg wHeld_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;

    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire awTake = s_axi_awvalid && s_axi_awready;
    wire wTake = s_axi_wvalid && s_axi_wready;
    wire awHave = awHeld_q || awTake;
    wire wHave = wHeld_q || wTake;
    wire [3:0] wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
    wire [31:0] wrData = wHeld_q ? wData_q : s_axi_wdata;
    wire [3:0] wrStrb = wHeld_q ? wStrb_q : s_axi_wstrb;
    wire wrFire = awHave && wHave && !s_axi_bvalid;

    always @(posedge core_clk) begin
        if (!rstn) begin
            awHeld_q <= 1'b0;
            awAddr_q <= 4'h0;
            wHeld_q <= 1'b0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RIJMP_RESP_OKAY;
            ctrl_q <= `RIJMP_CTRL_RESET;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wrFire) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wrAddr == `RIJMP_OFF_CTRL) begin
                    s_axi_bresp <= `RIJMP_RESP_OKAY;
                    if (wrStrb[0]) begin
                        ctrl_q <= wrData[2:0];
                    end
                end else if (wrAddr == `RIJMP_OFF_STATUS ||
                    wrAddr == `RIJMP_OFF_TARGET ||
                    wrAddr == `RIJMP_OFF_COUNT) begin
                    // Read-only registers ignore writes.
                    s_axi_bresp <= `RIJMP_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `RIJMP_RESP_SLVERR;
                end
            end else begin
                if (awTake) begin
                    awHeld_q <= 1'b1;
                    awAddr_q <= s_axi_awaddr;
                end
                if (wTake) begin
                    wHeld_q <= 1'b1;
                    wData_q <= s_axi_wdata;
                    wStrb_q <= s_axi_wstrb;
                end
            end
        end
    end

    reg [31:0] rdMux;
    reg rdHit;

    always @* begin
        rdMux = 32'h00000000;
        rdHit = 1'b1;
        case (s_axi_araddr)
            `RIJMP_OFF_CTRL: begin
                rdMux = {29'h00000000, ctrl_q};
            end
            `RIJMP_OFF_STATUS: begin
                rdMux = {28'h0000000, lastResInst_q, lastAddrErr_q,
                    slotPending, instruction_set_mode_bit};
            end
            `RIJMP_OFF_TARGET: begin
                rdMux = lastTarget_q;
            end
            `RIJMP_OFF_COUNT: begin
                rdMux = jumpCount_q;
            end
            default: begin
                rdHit = 1'b0;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RIJMP_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdMux;
                s_axi_rresp <= rdHit ? `RIJMP_RESP_OKAY :
                    `RIJMP_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // rijmp_unit

// ---- bench/rijmp_unit_chk.sv ----
// Checker on the jump unit's pipeline ports.
`timescale 1ns/1ps
module rijmp_unit_chk (
    input core_clk,
    input rstn,
    input instValid,
    input [31:0] instWord,
    input [31:0] instPc,
    input [31:0] baseValue,
    input linkWe,
    input [4:0] linkAddr,
    input [31:0] linkData,
    input redirectValid,
    input [31:0] redirectPc,
    input instruction_set_mode_bit,
    input addrError,
    input reservedInst,
    input slotPending
);
    wire [5:0] op = instWord[31:26];
    wire idx = instValid && op[5:4] == 2'h3 && op[2:0] == 3'h6 &&
        instWord[25:21] == 5'h00;
    wire lnk = idx && op[3];
    wire go = idx && !slotPending;
    wire rj = instValid && op == 6'h00 && instWord[5:1] == 5'h04;
    wire sv = slotPending && instValid;
    wire [31:0] sum = baseValue + {{16{instWord[15]}}, instWord[15:0]};
    wire [30:0] sumHi = sum[31:1];
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    link_value_a: assert property (linkWe |-> linkAddr == 5'h1f &&
        linkData == $past(instPc) + 32'h4) else $error("bad link");
    link_cause_a: assert property (linkWe |-> $past(lnk))
        else $error("stray link");
    jump_taken_a: assert property (go |=> redirectValid)
        else $error("no redirect");
    jump_target_a: assert property (go |=>
        redirectPc[31:1] == $past(sumHi)) else $error("bad target");
    align_err_a: assert property (redirectValid && !instruction_set_mode_bit &&
        redirectPc[1:0] == 2'h2 |-> addrError) else $error("missed error");
    align_ok_a: assert property (redirectValid &&
        redirectPc[1:0] == 2'h0 |-> !addrError) else $error("false error");
    slot_exc_a: assert property (reservedInst |->
        !redirectValid && $past(sv)) else $error("bad reserved");
    slot_end_a: assert property (sv |=>
        !slotPending && redirectValid != reservedInst) else $error("slot");
    slot_start_a: assert property ($rose(slotPending) |-> $past(rj))
        else $error("stray slot");
endmodule // rijmp_unit_chk

bind rijmp_unit rijmp_unit_chk chk (.core_clk, .rstn, .instValid,
    .instWord, .instPc, .baseValue, .linkWe, .linkAddr, .linkData,
    .redirectValid, .redirectPc, .instruction_set_mode_bit, .addrError, .reservedInst,
    .slotPending);

// ---- bench/rijmp_gpr_model.sv ----
// Register file model on the far side of the jump unit.
`timescale 1ns/1ps
module rijmp_gpr_model (
    input core_clk,
    input [4:0] baseRegAddr,
    input [4:0] srcRegAddr,
    input linkWe,
    input [4:0] linkAddr,
    input [31:0] linkData,
    output [31:0] baseValue,
    output [31:0] srcValue
);
    logic [31:0] gpr [0:31];
    // Reads are combinational, so a base of 31 is seen before the link lands.
    assign baseValue = baseRegAddr == 5'h00 ? 32'h0 : gpr[baseRegAddr];
    assign srcValue = srcRegAddr == 5'h00 ? 32'h0 : gpr[srcRegAddr];
    always @(posedge core_clk) begin
        if (linkWe) begin
            gpr[linkAddr] <= linkData;
        end
    end
endmodule // rijmp_gpr_model

// ---- bench/tb_rijmp_unit.sv ----
// Directed bench for the register indirect jump unit.
`timescale 1ns/1ps
module tb_rijmp_unit;
    logic core_clk = 1'h0, rstn = 1'h0, instValid = 1'h0;
    logic slotInstIsCti = 1'h0, awValid = 1'h0, wValid = 1'h0;
    logic arValid = 1'h0, respRdy = 1'h0;
    logic [31:0] instWord = 32'h0, instPc = 32'h0, wData = 32'h0;
    logic [31:0] rdata, t;
    logic [3:0] axAddr = 4'h0, wStrb = 4'hf;
    logic [1:0] resp;
    wire [31:0] baseValue, srcValue, linkData, redirectPc, rData;
    wire [4:0] baseRegAddr, srcRegAddr, linkAddr;
    wire [1:0] bResp, rResp;
    wire linkWe, redirectValid, instruction_set_mode_bit, addrError, hazardClear;
    wire reservedInst, slotPending, awRdy, wRdy, bValid, arRdy, rValid;
    int fails = 0, comparisons = 0;
    always #50 core_clk = ~core_clk;
    rijmp_unit dut (.core_clk, .rstn, .instValid, .instWord, .instPc,
        .baseValue, .srcValue, .slotInstIsCti, .baseRegAddr, .srcRegAddr,
        .linkWe, .linkAddr, .linkData, .redirectValid, .redirectPc,
        .instruction_set_mode_bit, .addrError, .hazardClear, .reservedInst, .slotPending,
        .s_axi_awaddr(axAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awRdy), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wRdy), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(respRdy),
        .s_axi_araddr(axAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arRdy), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(respRdy));
    rijmp_gpr_model gm (.core_clk, .baseRegAddr, .srcRegAddr, .linkWe,
        .linkAddr, .linkData, .baseValue, .srcValue);
    task chk(input [31:0] s, input [31:0] e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("unexpected %0t: saw %h want %h", $time, s, e);
        end
    endtask
    // Readies are sampled mid-cycle; they only move after a rising edge.
    task bus(input w, input [3:0] a, input [31:0] d);
        logic ka, kw, k;
        k = 1'h0;
        // A fresh edge first: no signal is driven twice in one step, and
        // state updated by the previous jump has landed before the read.
        @(posedge core_clk);
        axAddr <= a;
        wData <= d;
        awValid <= w;
        wValid <= w;
        arValid <= !w;
        respRdy <= 1'h1;
        while (!k) begin
            @(negedge core_clk);
            ka = w ? awRdy : arRdy;
            kw = wRdy;
            k = w ? bValid : rValid;
            resp = w ? bResp : rResp;
            rdata = rData;
            @(posedge core_clk);
            if (ka) awValid <= 1'h0;
            if (ka) arValid <= 1'h0;
            if (kw) wValid <= 1'h0;
        end
        respRdy <= 1'h0;
    endtask
    task issue(input [31:0] w, input c);
        @(posedge core_clk);
        instValid <= 1'h1;
        instWord <= w;
        instPc <= instPc + 32'h8;
        slotInstIsCti <= c;
        @(posedge core_clk);
        instValid <= 1'h0;
        #1;
    endtask
    task rjump(input [5:0] f, input [4:0] h, input c);
        issue({6'h0, 5'h7, 10'h0, h, f}, 1'h0);
        chk(slotPending, 1'h1);
        issue(32'h0, c);
        chk(slotPending, 1'h0);
    endtask
    task final_report;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        final_report;
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'h1;
        gm.gpr[5] = 32'h1000;
        gm.gpr[7] = 32'h3001;
        gm.gpr[31] = 32'h2000;
        bus(1'h0, 4'h0, 32'h0);
        chk(rdata, 32'h4);
        bus(1'h0, 4'h2, 32'h0);
        chk(resp, 2'h2);
        for (int c = 0; c < 2; c++) begin
            bus(1'h1, 4'h0, c ? 32'h6 : 32'h5);
            for (int i = 0; i < 4; i++) begin
                t = 32'h0ff0 + i;
                issue({i[0] ? 6'h36 : 6'h3e, 10'h5, 16'hfff0 + i[15:0]},
                    1'h0);
                chk(redirectValid, 1'h1);
                chk(redirectPc, c ? t & ~32'h1 : t);
                chk(addrError, c ? !t[0] && t[1] : |t[1:0]);
                chk(linkWe, !i[0]);
                if (!i[0]) chk(linkData, instPc + 32'h4);
                if (c) chk(instruction_set_mode_bit, t[0]);
            end
        end
        issue({6'h3e, 10'h65, 16'h0010}, 1'h0);
        chk(redirectValid, 1'h0);
        // The loop's linking jumps overwrote register 31.
        gm.gpr[31] = 32'h2000;
        issue({6'h3e, 10'h1f, 16'h0}, 1'h0);
        chk(redirectPc, 32'h2000);
        rjump(6'h09, 5'h10, 1'h0);
        chk(redirectPc, 32'h3000);
        chk(instruction_set_mode_bit, 1'h1);
        chk(hazardClear, 1'h1);
        rjump(6'h09, 5'h10, 1'h1);
        chk(reservedInst, 1'h1);
        issue({6'h0, 5'h7, 15'h0, 6'h08}, 1'h0);
        chk(slotPending, 1'h0);
        bus(1'h1, 4'h0, 32'h2);
        gm.gpr[7] = 32'h3002;
        rjump(6'h08, 5'h0, 1'h1);
        chk(hazardClear, 1'h0);
        chk(addrError, 1'h1);
        bus(1'h0, 4'h8, 32'h0);
        chk(rdata, 32'h3002);
        bus(1'h0, 4'hc, 32'h0);
        chk(rdata, 32'hb);
        bus(1'h0, 4'h4, 32'h0);
        chk(rdata, 32'h4);
        wStrb <= 4'h0;
        bus(1'h1, 4'h0, 32'h5);
        bus(1'h0, 4'h0, 32'h0);
        chk(rdata, 32'h2);
        final_report;
    end
endmodule // tb_rijmp_unit
